// ===== include/adc_readout_pkg.sv
// Shared constants and types of the converter serial readout.
// Assumes a single system clock; select, serial clock and comparator pins are synchronised in the top.
package adc_readout_pkg;
   // ********************************************************
   // Result coding
   // ********************************************************
   localparam int CODE_WIDTH = 12;
   localparam int LSB_DIVISOR = 4096;
   typedef logic [CODE_WIDTH-1:0] code_t;
   typedef logic [3:0] index_t;
   localparam code_t ZERO_CODE = 12'h000;
   localparam code_t MIDSCALE_CODE = 12'h800;
   localparam code_t FULL_SCALE_CODE = 12'hFFF;
   localparam index_t RESULT_MSB_IDX = 4'hB;
   localparam index_t RESULT_LSB_IDX = 4'h0;
   localparam index_t REPEAT_START_IDX = 4'h1;
   localparam index_t REPEAT_END_IDX = 4'hC;

   // ********************************************************
   // Approximation register control
   // ********************************************************
   typedef struct packed {
      logic clear;
      logic decide;
      index_t index;
   } sar_ctrl_s;

   typedef enum logic [2:0] {
      st_off,
      st_sample,
      st_null,
      st_convert,
      st_repeat,
      st_done
   } readout_state_e;
endpackage : adc_readout_pkg

// ===== src/sar_register.sv
// Successive-approximation register: trial code and decided result.
// Assumes the comparator level arrives already synchronised.
`timescale 1ns/1ps
`default_nettype none
module sar_register
   import adc_readout_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire adc_readout_pkg::sar_ctrl_s ctrl_i,
   input wire logic comp_i,
   output adc_readout_pkg::code_t trial_o,
   output adc_readout_pkg::code_t result_o
);
   // ********************************************************
   // One decision slice per bit
   // ********************************************************
   genvar i;
   generate
      for (i = 0; i < CODE_WIDTH; i++)
      begin : g_bit
         always_ff @(posedge sys_clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
            begin
               trial_o[i] <= 1'b0;
               result_o[i] <= 1'b0;
            end
            else if (ctrl_i.clear)
            begin
               // Trial starts at midscale so the first decision splits the range
               trial_o[i] <= MIDSCALE_CODE[i];
               result_o[i] <= ZERO_CODE[i];
            end
            else if (ctrl_i.decide && ctrl_i.index == 4'(i))
            begin
               trial_o[i] <= comp_i;
               result_o[i] <= comp_i;
            end
            else if (ctrl_i.decide && ctrl_i.index == 4'(i + 1))
            begin
               trial_o[i] <= 1'b1;
            end
         end
      end
   endgenerate
endmodule : sar_register
`default_nettype wire

// ===== src/sar_adc_serial_readout.sv
// Digital side of a 12-bit SAR converter with a 3-wire serial readout.
// Assumes select, serial clock and comparator are asynchronous to sys_clk_i
// and that the serial clock is far slower than sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout
   import adc_readout_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic select_shutdown_n_i,
   input wire logic serial_clock_i,
   input wire logic comparator_i,
   output logic serial_data_o,
   output logic serial_data_oe_n_o,
   output adc_readout_pkg::code_t trial_code_o,
   output logic sample_o,
   output logic analog_power_o,
   output logic digital_power_o
);
   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   logic sel_meta;
   logic sel_n_s;
   logic sclk_meta;
   logic sclk_s;
   logic sclk_prev;
   logic comp_meta;
   logic comp_s;
   logic sclk_fall;
   logic sel_low;

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sel_meta <= 1'b1;
         sel_n_s <= 1'b1;
         sclk_meta <= 1'b0;
         sclk_s <= 1'b0;
         sclk_prev <= 1'b0;
         comp_meta <= 1'b0;
         comp_s <= 1'b0;
      end
      else
      begin
         sel_meta <= select_shutdown_n_i;
         sel_n_s <= sel_meta;
         sclk_meta <= serial_clock_i;
         sclk_s <= sclk_meta;
         sclk_prev <= sclk_s;
         comp_meta <= comparator_i;
         comp_s <= comp_meta;
      end
   end

   // Edge detect reads the second and third stages only, never the metastable one
   assign sclk_fall = sclk_prev & ~sclk_s;
   assign sel_low = ~sel_n_s;

   // ********************************************************
   // Sequence control
   // ********************************************************
   readout_state_e state;
   index_t bit_idx;
   logic first_edge;
   sar_ctrl_s sar_ctrl;
   code_t result;
   logic repeat_bit;

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state <= st_off;
         bit_idx <= RESULT_MSB_IDX;
         first_edge <= 1'b0;
      end
      else if (!sel_low)
      begin
         state <= st_off;
         bit_idx <= RESULT_MSB_IDX;
         first_edge <= 1'b0;
      end
      else
      begin
         case (state)
            st_off:
            begin
               state <= st_sample;
               first_edge <= 1'b0;
            end
            st_sample:
            begin
               if (sclk_fall && first_edge)
               begin
                  state <= st_null;
               end
               else if (sclk_fall)
               begin
                  first_edge <= 1'b1;
               end
            end
            st_null:
            begin
               if (sclk_fall)
               begin
                  state <= st_convert;
                  bit_idx <= bit_idx - 4'h1;
               end
            end
            st_convert:
            begin
               if (sclk_fall && bit_idx == RESULT_LSB_IDX)
               begin
                  state <= st_repeat;
                  bit_idx <= REPEAT_START_IDX;
               end
               else if (sclk_fall)
               begin
                  bit_idx <= bit_idx - 4'h1;
               end
            end
            st_repeat:
            begin
               if (sclk_fall && bit_idx == REPEAT_END_IDX)
               begin
                  state <= st_done;
               end
               else if (sclk_fall)
               begin
                  bit_idx <= bit_idx + 4'h1;
               end
            end
            // Held until select goes high; clocks alone never restart
            st_done: state <= st_done;
            default: state <= st_off;
         endcase
      end
   end

   always_comb
   begin
      sar_ctrl.clear = (state == st_sample);
      sar_ctrl.decide = sclk_fall && sel_low && (state == st_null || state == st_convert);
      sar_ctrl.index = bit_idx;
   end

   sar_register u_sar
   (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .ctrl_i(sar_ctrl),
      .comp_i(comp_s),
      .trial_o(trial_code_o),
      .result_o(result)
   );

   assign repeat_bit = (bit_idx <= RESULT_MSB_IDX) ? result[bit_idx] : 1'b0;

   // ********************************************************
   // Serial output
   // ********************************************************
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         serial_data_o <= 1'b0;
         serial_data_oe_n_o <= 1'b1;
      end
      else if (!sel_low)
      begin
         serial_data_o <= 1'b0;
         serial_data_oe_n_o <= 1'b1;
      end
      else if (sclk_fall)
      begin
         case (state)
            st_sample:
            begin
               if (first_edge)
               begin
                  serial_data_o <= 1'b0;
                  serial_data_oe_n_o <= 1'b0;
               end
            end
            // Fresh decision goes straight to the pin so a short cycle keeps it
            st_null, st_convert: serial_data_o <= comp_s;
            st_repeat:
            begin
               if (bit_idx == REPEAT_END_IDX)
               begin
                  serial_data_o <= 1'b0;
                  serial_data_oe_n_o <= 1'b1;
               end
               else
               begin
                  serial_data_o <= repeat_bit;
               end
            end
            default: serial_data_o <= serial_data_o;
         endcase
      end
   end

   // ********************************************************
   // Power and sampling
   // ********************************************************
   assign sample_o = (state == st_sample);
   assign analog_power_o = (state == st_sample || state == st_null || state == st_convert);
   assign digital_power_o = (state != st_off);

   // ********************************************************
   // Checks
   // ********************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_deselect_tristate: assert property (sel_n_s |=> serial_data_oe_n_o)
      else $error("output driven while deselected");
   a_deselect_powerdown: assert property (sel_n_s |=> !analog_power_o && !digital_power_o)
      else $error("not fully powered down while deselected");
   a_null_bit_low: assert property (state == st_sample && first_edge && sclk_fall && sel_low
      |=> !serial_data_oe_n_o && !serial_data_o)
      else $error("leading low bit missing");
   a_decision_driven: assert property (state == st_convert && sclk_fall && sel_low
      |=> serial_data_o == $past(comp_s))
      else $error("decision not driven at once");
   a_msb_matches: assert property (state == st_null && sclk_fall && sel_low
      |=> serial_data_o == result[RESULT_MSB_IDX] && state == st_convert)
      else $error("msb out of order");
   a_repeat_order: assert property (state == st_repeat && sclk_fall && sel_low
      && bit_idx != REPEAT_END_IDX |=> serial_data_o == $past(repeat_bit))
      else $error("repeat bit wrong");
   a_done_holds: assert property (state == st_done && sel_low |=> state == st_done
      && serial_data_oe_n_o)
      else $error("restart without select cycle");
   a_done_power: assert property (state == st_done |-> !analog_power_o && digital_power_o)
      else $error("power state wrong after conversion");
   a_one_bit_edge: assert property (state == st_convert && !sclk_fall && sel_low
      |=> $stable(bit_idx))
      else $error("bit advanced without clock edge");
   a_midscale_trial: assert property (state == st_null |-> trial_code_o == MIDSCALE_CODE)
      else $error("first trial not midscale");

   c_full_conversion: cover property (state == st_repeat ##1 state == st_done);
   c_short_cycle: cover property (state == st_convert && sel_n_s);
   c_first_decision: cover property (state == st_null ##1 state == st_convert);
endmodule : sar_adc_serial_readout
`default_nettype wire

// ===== verif/adc_host_model.sv
// Host model: serial master plus an ideal analog input behind the comparator.
// Assumes the readout samples its pins on sys_clk_i and decides on clock falls.
`timescale 1ns/1ps
`default_nettype none
module adc_host_model
   import adc_readout_pkg::*;
(
   input wire logic sys_clk_i,
   output logic select_shutdown_n_o,
   output logic serial_clock_o,
   output logic comparator_o,
   input wire adc_readout_pkg::code_t trial_code_i,
   input wire logic serial_data_i,
   input wire logic serial_data_oe_n_i
);
   // ********************************************************
   // Pacing
   // ********************************************************
   // Half period kept wide so the comparator clears its sync flops
   localparam int HALF = 10;
   localparam int FRAME_CYCLES = 1000;
   code_t analog;
   // Counter has one writer only, so no time-zero race with its clear
   int cyc = 0;
   int start_cyc;
   initial
   begin
      analog = 12'h000;
      select_shutdown_n_o = 1'b1;
      serial_clock_o = 1'b0;
   end
   always @(posedge sys_clk_i) cyc <= cyc + 1;
   // Ideal input: high while input is at or above the trial code
   assign comparator_o = (analog >= trial_code_i);

   task automatic begin_frame(input code_t code);
      @(negedge sys_clk_i);
      analog = code;
      start_cyc = cyc;
      select_shutdown_n_o = 1'b0;
      repeat (HALF) @(negedge sys_clk_i);
   endtask : begin_frame

   // One clock period; output looked at late in the low half
   task automatic pulse(output logic d, output logic oe_n);
      serial_clock_o = 1'b1;
      repeat (HALF) @(negedge sys_clk_i);
      serial_clock_o = 1'b0;
      repeat (HALF) @(negedge sys_clk_i);
      d = serial_data_i;
      oe_n = serial_data_oe_n_i;
   endtask : pulse

   // Deselect, then idle so starts stay under the top rate
   task automatic end_frame();
      select_shutdown_n_o = 1'b1;
      repeat (HALF) @(negedge sys_clk_i);
      while (cyc - start_cyc < FRAME_CYCLES) @(negedge sys_clk_i);
   endtask : end_frame
endmodule : adc_host_model
`default_nettype wire

// ===== verif/tb_sar_adc_serial_readout.sv
// Self-checking bench for the serial readout.
// Assumes the host model paces the serial clock slowly against sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t value mismatch", $time); end end
module tb_sar_adc_serial_readout;
   import adc_readout_pkg::*;
   // ********************************************************
   // Harness
   // ********************************************************
   logic sys_clk;
   logic reset_n;
   wire logic sel_n;
   wire logic sclk;
   wire logic comp;
   logic sdata;
   logic oe_n;
   code_t trial;
   logic sample;
   logic apwr;
   logic dpwr;
   int miscompares = 0;
   int n_checks = 0;
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   sar_adc_serial_readout u_dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .select_shutdown_n_i(sel_n), .serial_clock_i(sclk), .comparator_i(comp),
      .serial_data_o(sdata), .serial_data_oe_n_o(oe_n), .trial_code_o(trial),
      .sample_o(sample), .analog_power_o(apwr), .digital_power_o(dpwr));
   adc_host_model u_host (.sys_clk_i(sys_clk), .select_shutdown_n_o(sel_n),
      .serial_clock_o(sclk), .comparator_o(comp), .trial_code_i(trial),
      .serial_data_i(sdata), .serial_data_oe_n_i(oe_n));

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // ********************************************************
   // Scenarios
   // ********************************************************
   task automatic run_frame(input code_t code, input int falls);
      logic d;
      logic oe;
      u_host.begin_frame(code);
      `CHK(sample, 1'b1)
      for (int k = 1; k <= falls; k++)
      begin
         u_host.pulse(d, oe);
         if (k == 1)
            `CHK(oe, 1'b1)
         else if (k == 2)
            `CHK({oe, d, sample}, 3'h0)
         else if (k <= 14)
            `CHK({oe, d}, {1'b0, code[14-k]})
         else if (k <= 25)
            `CHK({oe, d}, {1'b0, code[k-14]})
         else
            `CHK(oe, 1'b1)
      end
      if (falls >= 26)
         `CHK({apwr, dpwr}, 2'h1)
      u_host.end_frame();
      `CHK({oe_n, apwr, dpwr}, 3'h4)
   endtask : run_frame

   // Boundary codes of the straight binary scale, plus the mid-range code 12'hA5C
   task automatic t_codes();
      code_t codes[5] = '{12'h000, 12'h800, 12'h7FF, 12'hFFF, 12'hA5C};
      foreach (codes[i]) run_frame(codes[i], 26);
   endtask : t_codes

   // Cut short after the eighth result bit, then a clean restart
   task automatic t_abort();
      run_frame(12'h6C3, 10);
      run_frame(12'h39E, 26);
   endtask : t_abort

   // Clocking on with select low must not start again
   task automatic t_hold_low();
      run_frame(12'h555, 34);
   endtask : t_hold_low

   // Reset in mid-conversion drops everything
   task automatic t_reset_mid();
      logic d;
      logic oe;
      u_host.begin_frame(12'hC01);
      repeat (6) u_host.pulse(d, oe);
      reset_n = 1'b0;
      @(negedge sys_clk);
      `CHK({oe_n, dpwr, trial}, {2'h2, 12'h000})
      u_host.end_frame();
      reset_n = 1'b1;
      run_frame(12'h3FE, 26);
   endtask : t_reset_mid

   initial
   begin
      reset_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
      t_codes();
      t_abort();
      t_hold_low();
      t_reset_mid();
      conclude();
   end

   // Hang guard, well beyond the ten frames above
   initial
   begin
      #200000;
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
endmodule : tb_sar_adc_serial_readout
`default_nettype wire
